// ===== design/homing_defs.vh
// constants for the homing method selector
`ifndef HOMING_DEFS_VH
`define HOMING_DEFS_VH
`define METHOD_DATA_SET      4'h2
`define METHOD_STOPPER       4'h3
`define METHOD_SERVO_ON      4'h4
`define METHOD_DOG_REAR      4'h5
`define POS_W                32
`define SPD_W                16
`define TRQ_W                16
`define DWELL_W              16
`define DWELL_UNIT_NS        1000000
`define CLK_PERIOD_NS        10
`define DWELL_UNIT_CYCLES    (`DWELL_UNIT_NS / `CLK_PERIOD_NS)
`define TRQ_RESET            16'h0000
`define POS_RESET            32'h00000000
`define SPD_RESET            16'h0000
`endif

// ===== design/sync_bit.v
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module sync_bit
(
	// clock and reset
	input  wire clk_in,
	input  wire arst_n_in,
	// level
	input  wire d_in,
	output reg  q_out
);
	reg meta;

	always @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			meta  <= 1'b0;
			q_out <= 1'b0;
		end
		else
		begin
			meta  <= d_in;
			q_out <= meta;
		end
	end
endmodule // sync_bit

// ===== design/homing_sequence_selector.v
// homing sequence control for the positioning servo amplifier
`timescale 1ns/1ps
`include "homing_defs.vh"
// Functional notes
// - method code 2 takes any reached position as home.
// - on completion current position loads the home position value.
// - method code 3 homes by pressing against a mechanical stopper.
// - stopper homing moves at homing speed until stopper contact.
// - after contact wait dwell time, capture home, assert complete.
// - stopper homing clamps torque to the stopper torque limit.
// - stopper homing uses acceleration constant of point entry one.
// - torque-limit-reached asserts when torque meets the forward, reverse, internal or analog limit, never the stopper limit.
// - method code 4 makes the servo-on position home.
// - method code 5 is dog homing referenced to dog rear end.
// - slow at dog front, after rear travel after-dog plus shift.
// - rear-end homing never uses the encoder marker signal.
// - homing speed until dog detected, creep speed afterwards.
// - apply homing direction to the move command, dog polarity to the dog input.
// - dog edge sampling limits accuracy; error grows with creep speed.
// - rear-end homing uses accel/decel constants of point entry one.
module homing_sequence_selector
(
	// clock and reset
	input  wire                 clk_in,
	input  wire                 arst_n_in,
	// host link bits
	input  wire                 auto_manual_select_in,
	input  wire [4:0]           point_entry_select_low_in,
	input  wire [2:0]           point_entry_select_high_in,
	input  wire                 homing_start_in,
	// machine inputs
	input  wire                 servo_on_in,
	input  wire                 proximity_dog_in,
	input  wire                 stopper_contact_in,
	input  wire                 move_done_in,
	input  wire [`TRQ_W-1:0]    motor_torque_in,
	input  wire [`POS_W-1:0]    travelled_in,
	// parameters
	input  wire [3:0]           homing_method_param_in,
	input  wire                 homing_direction_param_in,
	input  wire                 dog_polarity_param_in,
	input  wire [`SPD_W-1:0]    homing_speed_param_in,
	input  wire [`SPD_W-1:0]    creep_speed_param_in,
	input  wire [`POS_W-1:0]    home_shift_distance_param_in,
	input  wire [`POS_W-1:0]    home_position_value_param_in,
	input  wire [`POS_W-1:0]    after_dog_distance_param_in,
	input  wire [`DWELL_W-1:0]  stopper_dwell_time_param_in,
	input  wire [`TRQ_W-1:0]    stopper_torque_limit_param_in,
	input  wire [`TRQ_W-1:0]    forward_torque_limit_param_in,
	input  wire [`TRQ_W-1:0]    reverse_torque_limit_param_in,
	input  wire [`TRQ_W-1:0]    internal_torque_limit_param_in,
	input  wire [`TRQ_W-1:0]    analog_torque_limit_input_in,
	input  wire [15:0]          point1_accel_time_in,
	input  wire [15:0]          point1_decel_time_in,
	// motion command
	output reg                  move_enable_out,
	output reg                  move_direction_out,
	output reg  [`SPD_W-1:0]    move_speed_out,
	output reg  [`POS_W-1:0]    move_distance_out,
	output reg                  move_distance_valid_out,
	output reg  [15:0]          accel_time_out,
	output reg  [15:0]          decel_time_out,
	output reg  [`TRQ_W-1:0]    torque_clamp_out,
	output reg                  torque_clamp_active_out,
	// status
	output reg  [`POS_W-1:0]    current_position_out,
	output reg                  homing_complete_out,
	output reg                  torque_limit_reached_out,
	output reg                  homing_busy_out,
	output reg                  homing_refused_out
);
	localparam [6:0] ST_IDLE  = 7'h01;
	localparam [6:0] ST_FAST  = 7'h02;
	localparam [6:0] ST_CREEP = 7'h04;
	localparam [6:0] ST_TAIL  = 7'h08;
	localparam [6:0] ST_PRESS = 7'h10;
	localparam [6:0] ST_DWELL = 7'h20;
	localparam [6:0] ST_DONE  = 7'h40;
	localparam [31:0] UNIT_CYC = `DWELL_UNIT_CYCLES;

	wire        s_manual;
	wire        s_start;
	wire        s_servo;
	wire        s_dog_raw;
	wire        s_stop;
	wire        s_done;
	wire [7:0]  s_point;
	wire [7:0]  point_raw;
	wire [5:0]  ctl_raw;
	wire [5:0]  ctl_sync;

	// host and machine levels arrive from outside the control cycle
	assign point_raw = {point_entry_select_high_in, point_entry_select_low_in};
	assign ctl_raw   = {servo_on_in, proximity_dog_in, stopper_contact_in, move_done_in,
		homing_start_in, auto_manual_select_in};

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : g_pt
			sync_bit u_pt
			(
				.clk_in    (clk_in),
				.arst_n_in (arst_n_in),
				.d_in      (point_raw[gi]),
				.q_out     (s_point[gi])
			);
		end
		for (gi = 0; gi < 6; gi = gi + 1)
		begin : g_ctl
			sync_bit u_ctl
			(
				.clk_in    (clk_in),
				.arst_n_in (arst_n_in),
				.d_in      (ctl_raw[gi]),
				.q_out     (ctl_sync[gi])
			);
		end
	endgenerate
	assign s_manual  = ctl_sync[0];
	assign s_start   = ctl_sync[1];
	assign s_done    = ctl_sync[2];
	assign s_stop    = ctl_sync[3];
	assign s_dog_raw = ctl_sync[4];
	assign s_servo   = ctl_sync[5];

	// dog level seen as active regardless of wiring sense
	wire dog_active = s_dog_raw ^ ~dog_polarity_param_in;
	// guard against launching in automatic mode or with a point entry picked
	wire launch_ok = s_manual & ~(|s_point);

	reg [6:0]           state;
	reg [6:0]           next_state;
	reg                 start_d;
	reg                 servo_d;
	reg                 dog_d;
	reg [31:0]          unit_cnt;
	reg [`DWELL_W-1:0]  dwell_cnt;
	reg [3:0]           method;
	reg                 next_move_enable;
	reg [`SPD_W-1:0]    next_move_speed;
	reg                 next_clamp_active;
	reg                 next_busy;
	reg                 next_complete;
	reg [`POS_W-1:0]    next_position;

	wire start_rise = s_start & ~start_d;
	wire servo_rise = s_servo & ~servo_d;
	wire dog_rise   = dog_active & ~dog_d;
	wire dog_fall   = ~dog_active & dog_d;
	wire dwell_end  = (dwell_cnt >= stopper_dwell_time_param_in);

	// torque compare against forward, reverse, internal and analog limits, not the stopper clamp
	wire trq_hit = (motor_torque_in >= forward_torque_limit_param_in)
		| (motor_torque_in >= reverse_torque_limit_param_in)
		| (motor_torque_in >= internal_torque_limit_param_in)
		| (motor_torque_in >= analog_torque_limit_input_in);

	always @*
	begin
		next_state = state;
		case (state)
			ST_IDLE:
			begin
				if (start_rise && launch_ok)
				begin
					case (homing_method_param_in)
						`METHOD_DATA_SET: next_state = ST_DONE;
						`METHOD_STOPPER:  next_state = ST_PRESS;
						`METHOD_DOG_REAR: next_state = ST_FAST;
						default:          next_state = ST_IDLE;
					endcase
				end
				else if (servo_rise && homing_method_param_in == `METHOD_SERVO_ON
					&& launch_ok)
					next_state = ST_DONE;
			end
			ST_FAST:
				if (dog_rise)
					next_state = ST_CREEP;
			ST_CREEP:
				if (dog_fall)
					next_state = ST_TAIL;
			ST_TAIL:
				if (s_done)
					next_state = ST_DONE;
			ST_PRESS:
				if (s_stop)
					next_state = ST_DWELL;
			ST_DWELL:
				if (!s_stop)
					next_state = ST_PRESS;
				else if (dwell_end)
					next_state = ST_DONE;
			ST_DONE:
				next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
		// leaving manual mode aborts any sequence under way
		if (!s_manual && state != ST_DONE)
			next_state = ST_IDLE;
	end

	always @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state     <= ST_IDLE;
			start_d   <= 1'b0;
			servo_d   <= 1'b0;
			dog_d     <= 1'b0;
			unit_cnt  <= 32'h00000000;
			dwell_cnt <= {`DWELL_W{1'b0}};
			method    <= 4'h0;
		end
		else
		begin
			state   <= next_state;
			start_d <= s_start;
			servo_d <= s_servo;
			// edge sampled once per cycle; position error follows creep speed
			dog_d   <= dog_active;
			if (state == ST_IDLE)
				method <= homing_method_param_in;
			if (state == ST_DWELL)
			begin
				if (unit_cnt >= UNIT_CYC - 32'h00000001)
				begin
					unit_cnt  <= 32'h00000000;
					dwell_cnt <= dwell_cnt + 1'b1;
				end
				else
					unit_cnt <= unit_cnt + 32'h00000001;
			end
			else
			begin
				unit_cnt  <= 32'h00000000;
				dwell_cnt <= {`DWELL_W{1'b0}};
			end
		end
	end

	// command for the state about to be entered, so outputs stay on flops
	always @*
	begin
		next_move_enable  = 1'b0;
		next_move_speed   = `SPD_RESET;
		next_clamp_active = 1'b0;
		next_busy         = 1'b1;
		case (next_state)
			ST_IDLE:
				next_busy = 1'b0;
			ST_FAST:
			begin
				next_move_enable = 1'b1;
				next_move_speed  = homing_speed_param_in;
			end
			ST_CREEP:
			begin
				next_move_enable = 1'b1;
				next_move_speed  = creep_speed_param_in;
			end
			ST_TAIL:
			begin
				next_move_enable = 1'b1;
				next_move_speed  = creep_speed_param_in;
			end
			ST_PRESS:
			begin
				next_move_enable  = 1'b1;
				next_move_speed   = homing_speed_param_in;
				next_clamp_active = 1'b1;
			end
			ST_DWELL:
				next_clamp_active = 1'b1;
			ST_DONE:
				next_busy = 1'b0;
			default:
				next_busy = 1'b0;
		endcase
	end

	// completion load wins over idle integration of travel
	always @*
	begin
		next_complete = homing_complete_out;
		next_position = current_position_out;
		if (next_state == ST_DONE)
		begin
			next_position = home_position_value_param_in;
			next_complete = 1'b1;
		end
		else if (next_state != ST_IDLE)
			next_complete = 1'b0;
		else if (state == ST_IDLE && !s_manual)
			next_complete = homing_complete_out;
		else
			next_position = current_position_out + travelled_in;
	end

	// motion command and status registers
	always @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			move_enable_out          <= 1'b0;
			move_direction_out       <= 1'b0;
			move_speed_out           <= `SPD_RESET;
			move_distance_out        <= `POS_RESET;
			move_distance_valid_out  <= 1'b0;
			accel_time_out           <= 16'h0000;
			decel_time_out           <= 16'h0000;
			torque_clamp_out         <= `TRQ_RESET;
			torque_clamp_active_out  <= 1'b0;
			current_position_out     <= `POS_RESET;
			homing_complete_out      <= 1'b0;
			torque_limit_reached_out <= 1'b0;
			homing_busy_out          <= 1'b0;
			homing_refused_out       <= 1'b0;
		end
		else
		begin
			torque_limit_reached_out <= trq_hit;
			homing_busy_out <= next_busy;
			homing_refused_out <= start_rise && !launch_ok;
			move_direction_out <= homing_direction_param_in;
			move_enable_out <= next_move_enable;
			move_speed_out <= next_move_speed;
			// remaining travel past rear end; marker pulse not consulted
			move_distance_out <= after_dog_distance_param_in
				+ home_shift_distance_param_in;
			move_distance_valid_out <= (next_state == ST_TAIL);
			accel_time_out <= point1_accel_time_in;
			decel_time_out <= (method == `METHOD_DOG_REAR) ? point1_decel_time_in
				: 16'h0000;
			torque_clamp_active_out <= next_clamp_active;
			torque_clamp_out <= stopper_torque_limit_param_in;
			current_position_out <= next_position;
			homing_complete_out  <= next_complete;
		end
	end
endmodule // homing_sequence_selector

// ===== verif/machine_model.sv
// axis stand-in: stopper contact, proximity dog and tail travel
`timescale 1ns/1ps
module machine_model
(
	// clock
	input  wire logic clk_in,
	// motion command from the selector, and the dog polarity setting
	input  wire logic move_enable_in,
	input  wire logic move_distance_valid_in,
	input  wire logic dog_polarity_in,
	// sensed machine state
	output logic      stopper_contact_out,
	output logic      proximity_dog_out,
	output logic      move_done_out
);
	int pos;
	int tail;
	always @(posedge clk_in)
	begin
		pos <= move_enable_in ? pos + 1 : 0;
		tail <= move_distance_valid_in ? tail + 1 : 0;
	end
	// contact only after real travel, so the press phase can be seen
	assign stopper_contact_out = pos >= 20;
	assign proximity_dog_out = (pos >= 8 && pos < 16) ^ !dog_polarity_in;
	assign move_done_out = tail > 4;
endmodule // machine_model

// ===== verif/homing_chk.sv
// port checker for the homing selector
`timescale 1ns/1ps
`include "homing_defs.vh"
module homing_chk
(
	input wire logic clk_in, arst_n_in, auto_manual_select_in,
	input wire logic [4:0] point_entry_select_low_in,
	input wire logic [2:0] point_entry_select_high_in,
	input wire logic [3:0] homing_method_param_in,
	input wire logic homing_direction_param_in, move_enable_out, move_direction_out,
	input wire logic move_distance_valid_out, torque_clamp_active_out, homing_complete_out,
	input wire logic torque_limit_reached_out, homing_busy_out, homing_refused_out,
	input wire logic [`SPD_W-1:0] creep_speed_param_in, move_speed_out,
	input wire logic [`POS_W-1:0] home_shift_distance_param_in, after_dog_distance_param_in,
	input wire logic [`POS_W-1:0] home_position_value_param_in, move_distance_out,
	input wire logic [`POS_W-1:0] current_position_out,
	input wire logic [`TRQ_W-1:0] motor_torque_in, stopper_torque_limit_param_in,
	input wire logic [`TRQ_W-1:0] torque_clamp_out, forward_torque_limit_param_in,
	input wire logic [`TRQ_W-1:0] reverse_torque_limit_param_in, internal_torque_limit_param_in,
	input wire logic [`TRQ_W-1:0] analog_torque_limit_input_in,
	input wire logic [15:0] point1_accel_time_in, point1_decel_time_in, accel_time_out,
	input wire logic [15:0] decel_time_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	wire reach = motor_torque_in >= forward_torque_limit_param_in
		|| motor_torque_in >= reverse_torque_limit_param_in
		|| motor_torque_in >= internal_torque_limit_param_in
		|| motor_torque_in >= analog_torque_limit_input_in;
	// six cycles covers the two-stage sync plus edge detect
	wire blocked = !auto_manual_select_in || point_entry_select_low_in != 5'h0
		|| point_entry_select_high_in != 3'h0;
	a_clamp_value: assert property (torque_clamp_active_out |-> torque_clamp_out ==
		stopper_torque_limit_param_in && homing_method_param_in == `METHOD_STOPPER)
		else $error("clamp wrong");
	a_tail_distance: assert property (move_distance_valid_out |-> move_speed_out ==
		creep_speed_param_in && move_distance_out ==
		after_dog_distance_param_in + home_shift_distance_param_in) else $error("tail wrong");
	a_limit_reached: assert property ($past(arst_n_in, 2) |->
		torque_limit_reached_out == $past(reach)) else $error("limit flag wrong");
	a_home_load: assert property ($rose(homing_complete_out) |->
		current_position_out == home_position_value_param_in) else $error("home not loaded");
	a_blocked_launch: assert property (blocked [*6] |-> !$rose(homing_busy_out))
		else $error("launch while blocked");
	a_refuse_pulse: assert property (homing_refused_out |=> !homing_refused_out)
		else $error("refusal not a pulse");
	a_move_dir: assert property (move_enable_out |->
		move_direction_out == homing_direction_param_in) else $error("direction wrong");
	a_point_one: assert property (homing_busy_out |-> accel_time_out ==
		point1_accel_time_in && (homing_method_param_in != `METHOD_DOG_REAR
		|| decel_time_out == point1_decel_time_in)) else $error("time constant wrong");
	cover property ($rose(homing_complete_out) && homing_method_param_in == `METHOD_STOPPER);
	cover property ($rose(homing_complete_out) && homing_method_param_in == `METHOD_DOG_REAR);
	cover property (homing_refused_out);
endmodule // homing_chk
bind homing_sequence_selector homing_chk homing_chk_inst (.*);

// ===== verif/tb.sv
// self-checking bench for the homing selector
`timescale 1ns/1ps
`include "homing_defs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("unexpected at %0t got %h expected %h", $time, g, e); end end
module tb;
	logic clk_in = 1'h0, arst_n_in = 1'h0, auto_manual_select_in = 1'h1, seen;
	logic homing_start_in = 1'h0, servo_on_in = 1'h0, proximity_dog_in, stopper_contact_in;
	logic move_done_in, homing_direction_param_in = 1'h0, dog_polarity_param_in = 1'h1;
	logic [4:0] point_entry_select_low_in = '0;
	logic [2:0] point_entry_select_high_in = '0;
	logic [3:0] homing_method_param_in = 4'h2;
	logic [`TRQ_W-1:0] motor_torque_in = '0, stopper_torque_limit_param_in = '0;
	logic [`TRQ_W-1:0] forward_torque_limit_param_in = '0, reverse_torque_limit_param_in = '0;
	logic [`TRQ_W-1:0] internal_torque_limit_param_in = '0, analog_torque_limit_input_in = '0;
	logic [`POS_W-1:0] travelled_in = '0, home_shift_distance_param_in = '0;
	logic [`POS_W-1:0] home_position_value_param_in = '0, after_dog_distance_param_in = '0;
	logic [`SPD_W-1:0] homing_speed_param_in = '0, creep_speed_param_in = '0, move_speed_out;
	logic [`DWELL_W-1:0] stopper_dwell_time_param_in = '0;
	logic [15:0] point1_accel_time_in = '0, point1_decel_time_in = '0;
	logic [15:0] accel_time_out, decel_time_out;
	logic move_enable_out, move_direction_out, move_distance_valid_out, torque_clamp_active_out;
	logic homing_complete_out, torque_limit_reached_out, homing_busy_out, homing_refused_out;
	logic [`POS_W-1:0] move_distance_out, current_position_out;
	logic [`TRQ_W-1:0] torque_clamp_out;
	int errors = 0, compares = 0, i;
	homing_sequence_selector homing_sequence_selector_inst (.*);
	machine_model machine_model_inst (.clk_in(clk_in), .move_enable_in(move_enable_out),
		.move_distance_valid_in(move_distance_valid_out), .dog_polarity_in(dog_polarity_param_in),
		.stopper_contact_out(stopper_contact_in), .proximity_dog_out(proximity_dog_in),
		.move_done_out(move_done_in));
	always #5 clk_in = ~clk_in;
	function automatic logic reach_exp();
		return motor_torque_in >= forward_torque_limit_param_in
			|| motor_torque_in >= reverse_torque_limit_param_in
			|| motor_torque_in >= internal_torque_limit_param_in
			|| motor_torque_in >= analog_torque_limit_input_in;
	endfunction
	task automatic conclude;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// position equality guards against a stale completion flag
	task automatic await_home(input logic [`POS_W-1:0] home);
		for (int k = 0; k < 300; k++)
		begin
			@(negedge clk_in);
			if (homing_complete_out === 1'h1 && current_position_out === home)
				break;
		end
		`CHK(current_position_out, home)
		`CHK(homing_complete_out, 1'h1)
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_in);
		errors++;
		conclude;
	end
	initial
	begin
		i = $urandom(77228);
		repeat (3) @(posedge clk_in);
		arst_n_in <= 1'h1;
		point1_accel_time_in <= $urandom;
		point1_decel_time_in <= $urandom;
		after_dog_distance_param_in <= $urandom;
		home_shift_distance_param_in <= $urandom;
		stopper_torque_limit_param_in <= $urandom;
		for (i = 0; i < 2; i++)
		begin
			@(posedge clk_in);
			point_entry_select_low_in <= i ? 5'h0 : 5'h1 + $urandom % 31;
			point_entry_select_high_in <= i ? 3'h0 : $urandom;
			auto_manual_select_in <= (i == 0);
			homing_start_in <= 1'h1;
			seen = 1'h0;
			repeat (10) @(negedge clk_in) seen |= homing_refused_out;
			`CHK(seen, 1'h1)
			`CHK(homing_busy_out | homing_complete_out, 1'h0)
			@(posedge clk_in);
			homing_start_in <= 1'h0;
			point_entry_select_low_in <= 5'h0;
			point_entry_select_high_in <= 3'h0;
			auto_manual_select_in <= 1'h1;
			repeat (4) @(posedge clk_in);
		end
		homing_method_param_in <= `METHOD_SERVO_ON;
		home_position_value_param_in <= $urandom;
		repeat (2) @(posedge clk_in);
		servo_on_in <= 1'h1;
		await_home(home_position_value_param_in);
		for (i = 0; i < 4; i++)
		begin
			@(posedge clk_in);
			homing_method_param_in <= i == 0 ? `METHOD_DATA_SET : i == 1 ? `METHOD_STOPPER
				: `METHOD_DOG_REAR;
			dog_polarity_param_in <= i[0];
			homing_direction_param_in <= $urandom;
			home_position_value_param_in <= $urandom;
			homing_speed_param_in <= $urandom;
			creep_speed_param_in <= $urandom;
			repeat (2) @(posedge clk_in);
			homing_start_in <= 1'h1;
			repeat (8) @(posedge clk_in);
			@(negedge clk_in);
			if (i > 0) `CHK(move_speed_out, homing_speed_param_in)
			if (i == 1) `CHK(torque_clamp_active_out, 1'h1)
			@(posedge clk_in);
			homing_start_in <= 1'h0;
			await_home(home_position_value_param_in);
		end
		for (i = 0; i < 6; i++)
		begin
			@(posedge clk_in);
			forward_torque_limit_param_in <= 16'h8000 | $urandom;
			reverse_torque_limit_param_in <= 16'h8000 | $urandom;
			internal_torque_limit_param_in <= 16'h8000 | $urandom;
			analog_torque_limit_input_in <= 16'h8000 | $urandom;
			motor_torque_in <= $urandom;
			@(posedge clk_in);
			if (i == 0)
				motor_torque_in <= forward_torque_limit_param_in;
			repeat (2) @(negedge clk_in);
			`CHK(torque_limit_reached_out, reach_exp())
		end
		conclude;
	end
endmodule // tb
